//--- include/ocs_pkg.sv
// Constants for the oscillator clock-source selection block
package ocs_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [19:0] REG_TB_IDX   = 20'h0001d;
   localparam logic [19:0] REG_OPT_IDX  = 20'h0ffcf;
   localparam logic [19:0] REG_STAT_IDX = 20'h0001e;
   localparam logic [19:0] TB_ADDR      = {REG_TB_IDX[17:0], 2'h0};
   localparam logic [19:0] OPT_ADDR     = {REG_OPT_IDX[17:0], 2'h0};
   localparam logic [19:0] STAT_ADDR    = {REG_STAT_IDX[17:0], 2'h0};
   localparam int          ADDR_W       = 20;
   ////////////////////////////////////////////////////////////////////////
   // Option word fields
   localparam int MAIN_SEL_LO = 0;
   localparam int MAIN_SEL_HI = 1;
   // Timebase setup register fields
   localparam int TB_SEL_LO      = 0;
   localparam int TB_SEL_HI      = 1;
   localparam int STOP_RC_KEEP   = 2;
   localparam int STOP_XTAL_KEEP = 3;
   localparam int STOP_INT_OFF   = 4;
   // Status register fields
   localparam int ST_SEL_LO  = 0;
   localparam int ST_SEL_HI  = 1;
   localparam int ST_RING_EN = 2;
   localparam int ST_RC_EN   = 3;
   localparam int ST_XTAL_EN = 4;
   localparam int ST_STOP    = 5;
   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] OPT_RESET = 8'h01;
   localparam logic [7:0] TB_RESET  = 8'h00;
   // Main source encodings
   localparam logic [1:0] MAIN_NONE = 2'h0;
   localparam logic [1:0] MAIN_INT  = 2'h1;
   localparam logic [1:0] MAIN_RC   = 2'h2;
   localparam logic [1:0] MAIN_XTAL = 2'h3;
   // Timebase source encodings
   localparam logic [1:0] TB_INT  = 2'h0;
   localparam logic [1:0] TB_RC   = 2'h1;
   localparam logic [1:0] TB_XTAL = 2'h2;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hw/ocs_clock_select.sv
// Oscillator clock-source selection and gating with AXI4-Lite registers
`timescale 1ns/1ps
module ocs_clock_select (
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   input  wire logic                      ringClkIn,
   input  wire logic                      rcClkIn,
   input  wire logic                      xtalClkIn,
   input  wire logic                      oscInPin,
   input  wire logic                      busClk,
   input  wire logic                      oscGlobalEnable,
   input  wire logic                      waitMode,
   input  wire logic                      stopMode,
   input  wire logic                      breakMode,
   output logic                           mainRefClock,
   output logic                           pllRefBuffered,
   output logic                           timebaseRefClock,
   output logic                           watchdogRefClock,
   output logic                           oscOutPin,
   output logic                           ringEnable,
   output logic                           rcEnable,
   output logic                           xtalEnable,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [ocs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic [1:0]                     s_axi_bresp,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   input  wire logic [ocs_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]                optWord = ocs_pkg::OPT_RESET;
   logic [7:0]                tbSetup;
   logic [1:0]                mainSel;
   logic                      selCaptured;
   logic                      stopPrev;
   logic                      keepRc;
   logic                      keepXtal;
   logic                      intOff;
   logic                      next_keepRc;
   logic                      next_keepXtal;
   logic                      next_intOff;
   logic                      next_ringEn;
   logic                      next_rcEn;
   logic                      next_xtalEn;
   logic                      next_mainRef;
   logic                      next_tbRef;
   logic                      awHeld;
   logic                      wHeld;
   logic [ocs_pkg::ADDR_W-1:0] awAddrQ;
   logic [7:0]                wDataQ;
   logic                      wStrbQ;
   logic                      doWrite;

   // Address decode used by both bus channels
   function automatic logic isMapped(input logic [ocs_pkg::ADDR_W-1:0] a);
      isMapped = (a == ocs_pkg::TB_ADDR) || (a == ocs_pkg::OPT_ADDR) ||
                 (a == ocs_pkg::STAT_ADDR);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Source selection captured once after reset release.
   // A later option word write only takes effect at the next reset, so the
   // main clock mux never switches while downstream clocks run.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mainSel     <= ocs_pkg::MAIN_INT;
         selCaptured <= 1'b0;
      end else if (!selCaptured) begin
         mainSel     <= {optWord[ocs_pkg::MAIN_SEL_HI],
                         optWord[ocs_pkg::MAIN_SEL_LO]};
         selCaptured <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stop keep bits taken at stop entry, so changes during stop are ignored
   always_comb begin
      if (stopMode && !stopPrev) begin
         next_keepRc   = tbSetup[ocs_pkg::STOP_RC_KEEP];
         next_keepXtal = tbSetup[ocs_pkg::STOP_XTAL_KEEP];
         next_intOff   = tbSetup[ocs_pkg::STOP_INT_OFF];
      end else begin
         next_keepRc   = keepRc;
         next_keepXtal = keepXtal;
         next_intOff   = intOff;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stopPrev <= 1'b0;
         keepRc   <= 1'b0;
         keepXtal <= 1'b0;
         intOff   <= 1'b0;
      end else begin
         stopPrev <= stopMode;
         keepRc   <= next_keepRc;
         keepXtal <= next_keepXtal;
         intOff   <= next_intOff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator enables; wait and break play no part here
   always_comb begin
      next_ringEn = oscGlobalEnable &&
                    !(stopMode && next_intOff);
      next_rcEn   = oscGlobalEnable && mainSel == ocs_pkg::MAIN_RC &&
                    (!stopMode || next_keepRc);
      next_xtalEn = oscGlobalEnable && mainSel == ocs_pkg::MAIN_XTAL &&
                    (!stopMode || next_keepXtal);
   end

   // Clock muxes from the current enables
   always_comb begin
      case (mainSel)
         ocs_pkg::MAIN_INT:  next_mainRef = ringClkIn && next_ringEn;
         ocs_pkg::MAIN_RC:   next_mainRef = rcClkIn && next_rcEn;
         ocs_pkg::MAIN_XTAL: next_mainRef = xtalClkIn && next_xtalEn;
         default:            next_mainRef = 1'b0;
      endcase
      case ({tbSetup[ocs_pkg::TB_SEL_HI], tbSetup[ocs_pkg::TB_SEL_LO]})
         ocs_pkg::TB_INT:  next_tbRef = ringClkIn && next_ringEn;
         ocs_pkg::TB_RC:   next_tbRef = rcClkIn && next_rcEn;
         ocs_pkg::TB_XTAL: next_tbRef = xtalClkIn && next_xtalEn;
         default:          next_tbRef = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ringEnable       <= 1'b0;
         rcEnable         <= 1'b0;
         xtalEnable       <= 1'b0;
         mainRefClock     <= 1'b0;
         pllRefBuffered   <= 1'b0;
         timebaseRefClock <= 1'b0;
         watchdogRefClock <= 1'b0;
         oscOutPin        <= 1'b0;
      end else begin
         ringEnable       <= next_ringEn;
         rcEnable         <= next_rcEn;
         xtalEnable       <= next_xtalEn;
         mainRefClock     <= next_mainRef;
         pllRefBuffered   <= next_mainRef;
         timebaseRefClock <= next_tbRef;
         watchdogRefClock <= ringClkIn && next_ringEn;
         if (mainSel == ocs_pkg::MAIN_XTAL) begin
            oscOutPin <= !oscInPin;
         end else begin
            oscOutPin <= busClk;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel; one write at a time
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld        <= 1'b0;
         awAddrQ       <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld        <= 1'b1;
         awAddrQ       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         awHeld        <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wHeld        <= 1'b0;
         wDataQ       <= 8'h00;
         wStrbQ       <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld        <= 1'b1;
         wDataQ       <= s_axi_wdata[7:0];
         wStrbQ       <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         wHeld        <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ocs_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= isMapped(awAddrQ) ? ocs_pkg::RESP_OKAY
                                           : ocs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Option word is nonvolatile and survives arst_n, otherwise a written
   // main source could never reach the capture at reset release
   always_ff @(posedge sys_clk) begin
      if (doWrite && wStrbQ && awAddrQ == ocs_pkg::OPT_ADDR) begin
         optWord <= wDataQ;
      end
   end

   // Register storage; only byte lane 0 carries data
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tbSetup <= ocs_pkg::TB_RESET;
      end else if (doWrite && wStrbQ && awAddrQ == ocs_pkg::TB_ADDR) begin
         tbSetup <= wDataQ;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= ocs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= isMapped(s_axi_araddr) ? ocs_pkg::RESP_OKAY
                                                 : ocs_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            ocs_pkg::OPT_ADDR: s_axi_rdata <= {24'h000000, optWord};
            ocs_pkg::TB_ADDR:  s_axi_rdata <= {24'h000000, tbSetup};
            ocs_pkg::STAT_ADDR: s_axi_rdata <= {26'h0000000, stopMode,
                               xtalEnable, rcEnable, ringEnable, mainSel};
            default:           s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_stopEntry;
      !stopMode ##1 stopMode;
   endsequence

   property p_ringAfterReset;
      selCaptured && oscGlobalEnable && !stopMode |=> ringEnable;
   endproperty
   a_ringAfterReset: assert property (p_ringAfterReset)
      else $error("ring clock not enabled");

   property p_exclusive;
      !(rcEnable && xtalEnable);
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("rc and crystal both enabled");

   property p_selStatic;
      selCaptured |=> $stable(mainSel);
   endproperty
   a_selStatic: assert property (p_selStatic)
      else $error("main select changed after capture");

   property p_pllCopy;
      pllRefBuffered == mainRefClock;
   endproperty
   a_pllCopy: assert property (p_pllCopy)
      else $error("pll reference differs from main reference");

   property p_watchdog;
      oscGlobalEnable && !stopMode |=> watchdogRefClock == $past(ringClkIn);
   endproperty
   a_watchdog: assert property (p_watchdog)
      else $error("watchdog clock not ring clock");

   property p_outPin;
      selCaptured && mainSel != ocs_pkg::MAIN_XTAL |=>
         oscOutPin == $past(busClk);
   endproperty
   a_outPin: assert property (p_outPin)
      else $error("output pin not bus clock");

   property p_xtalPin;
      selCaptured && mainSel == ocs_pkg::MAIN_XTAL |=>
         oscOutPin == !$past(oscInPin);
   endproperty
   a_xtalPin: assert property (p_xtalPin)
      else $error("output pin not inverted input");

   property p_stopRc;
      s_stopEntry ##0 (mainSel == ocs_pkg::MAIN_RC && !keepRc &&
         !tbSetup[ocs_pkg::STOP_RC_KEEP]) |=> !rcEnable;
   endproperty
   a_stopRc: assert property (p_stopRc)
      else $error("rc still enabled in stop");

   property p_stopRing;
      s_stopEntry ##0 (tbSetup[ocs_pkg::STOP_INT_OFF] && oscGlobalEnable)
         |=> !ringEnable ##1 (!stopMode || !ringEnable);
   endproperty
   a_stopRing: assert property (p_stopRing)
      else $error("ring clock running in stop with internal off");

   property p_tbGate;
      tbSetup[ocs_pkg::TB_SEL_HI] && mainSel != ocs_pkg::MAIN_XTAL
         |=> !timebaseRefClock;
   endproperty
   a_tbGate: assert property (p_tbGate)
      else $error("timebase got crystal while not main source");

   property p_waitBreak;
      (waitMode || breakMode) && !stopMode && selCaptured &&
         mainSel == ocs_pkg::MAIN_INT && oscGlobalEnable
         |=> mainRefClock == $past(ringClkIn);
   endproperty
   a_waitBreak: assert property (p_waitBreak)
      else $error("main clock interrupted in wait or break");
endmodule

//--- sim/ocs_osc_model.sv
// Behavioural oscillator sources and bus clock facing the clock selector
`timescale 1ns/1ps
module ocs_osc_model (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic ringEnable,
   input  wire logic rcEnable,
   input  wire logic xtalEnable,
   output logic      ringClkIn,
   output logic      rcClkIn,
   output logic      xtalClkIn,
   output logic      oscInPin,
   output logic      busClk
);
   logic [3:0] cnt;
   ////////////////////////////////////////////////////////////////////////
   // Free counter; bus clock is its bit 1, ungated by the enables, and halts only while arst_n is low
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   assign busClk = cnt[1];
   ////////////////////////////////////////////////////////////////////////
   // A circuit that is switched off stands still at 0
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ringClkIn <= 1'b0;
         rcClkIn   <= 1'b0;
         xtalClkIn <= 1'b0;
      end else begin
         ringClkIn <= ringEnable & ~ringClkIn;
         rcClkIn   <= rcEnable & cnt[1];
         xtalClkIn <= xtalEnable & cnt[2];
      end
   end
   // Shared pin shows only the enabled source; else a toggling pattern
   // so a stale level cannot pass for a sampled one
   assign oscInPin = rcEnable ? rcClkIn
                   : (xtalEnable ? xtalClkIn : cnt[0]);
endmodule

//--- sim/tb_ocs_clock_select.sv
// Self-checking bench for the oscillator clock-source selector
`timescale 1ns/1ps
module tb_ocs_clock_select;
   logic        sys_clk, arst_n, ringClkIn, rcClkIn, xtalClkIn, oscInPin;
   logic        busClk, oscGlobalEnable, waitMode, stopMode, breakMode;
   logic        mainRefClock, pllRefBuffered, timebaseRefClock;
   logic        watchdogRefClock, oscOutPin, ringEnable, rcEnable;
   logic        xtalEnable, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [1:0]  expSel = ocs_pkg::MAIN_INT;
   logic [1:0]  expTb = ocs_pkg::TB_INT;
   int          nMismatch = 0;
   int          checks = 0;
   ////////////////////////////////////////////////////////////////////////
   ocs_clock_select i_ocs_clock_select (
      .sys_clk(sys_clk), .arst_n(arst_n), .ringClkIn(ringClkIn),
      .rcClkIn(rcClkIn), .xtalClkIn(xtalClkIn), .oscInPin(oscInPin),
      .busClk(busClk), .oscGlobalEnable(oscGlobalEnable),
      .waitMode(waitMode), .stopMode(stopMode), .breakMode(breakMode),
      .mainRefClock(mainRefClock), .pllRefBuffered(pllRefBuffered),
      .timebaseRefClock(timebaseRefClock),
      .watchdogRefClock(watchdogRefClock), .oscOutPin(oscOutPin),
      .ringEnable(ringEnable), .rcEnable(rcEnable),
      .xtalEnable(xtalEnable), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp));
   ocs_osc_model i_ocs_osc_model (
      .sys_clk(sys_clk), .arst_n(arst_n), .ringEnable(ringEnable),
      .rcEnable(rcEnable), .xtalEnable(xtalEnable),
      .ringClkIn(ringClkIn), .rcClkIn(rcClkIn), .xtalClkIn(xtalClkIn),
      .oscInPin(oscInPin), .busClk(busClk));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      checks++;
      if (s !== e) begin
         nMismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Write with address and data offered together; waits are bounded
   task automatic axiWr(input logic [19:0] a, input logic [31:0] d,
                        input logic [1:0] er);
      int  n;
      bit  aDone, wDone;
      n = 0;
      aDone = 0;
      wDone = 0;
      @(posedge sys_clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
      bready <= 1'b1;
      while (!(aDone && wDone) && n < 50) begin
         @(posedge sys_clk);
         n++;
         if (awvalid && awready) begin aDone = 1; awvalid <= 1'b0; end
         if (wvalid && wready) begin wDone = 1; wvalid <= 1'b0; end
      end
      while (!bvalid && n < 100) begin @(posedge sys_clk); n++; end
      if (n >= 100) nMismatch++;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
   endtask
   task automatic axiRd(input logic [19:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
      int n;
      n = 0;
      @(posedge sys_clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (!arready && n < 50);
      arvalid <= 1'b0;
      while (!rvalid && n < 100) begin @(posedge sys_clk); n++; end
      if (n >= 100) nMismatch++;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      chk("rdata", ed, rdata);
      rready <= 1'b0;
   endtask
   // Outputs are registered copies of the previous cycle's inputs
   task automatic watch(input int n, input bit mainOn, input bit tbOn);
      logic pm, pt, pr, pb, pi;
      for (int i = 0; i <= n; i++) begin
         @(negedge sys_clk);
         if (i > 0) begin
            chk("mainRefClock", mainOn ? pm : 1'b0, mainRefClock);
            chk("pllRefBuffered", mainOn ? pm : 1'b0,
                pllRefBuffered);
            chk("timebaseRefClock", tbOn ? pt : 1'b0,
                timebaseRefClock);
            chk("watchdogRefClock", pr, watchdogRefClock);
            chk("oscOutPin", expSel == ocs_pkg::MAIN_XTAL ? !pi : pb,
                oscOutPin);
         end
         pr = ringClkIn;
         pb = busClk;
         pi = oscInPin;
         pm = expSel == ocs_pkg::MAIN_XTAL ? xtalClkIn
            : (expSel == ocs_pkg::MAIN_RC ? rcClkIn : ringClkIn);
         pt = expTb == ocs_pkg::TB_XTAL ? xtalClkIn
            : (expTb == ocs_pkg::TB_RC ? rcClkIn : ringClkIn);
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tResetValues();
      axiRd(ocs_pkg::OPT_ADDR, 32'h01, ocs_pkg::RESP_OKAY);
      axiRd(ocs_pkg::TB_ADDR, 32'h00, ocs_pkg::RESP_OKAY);
      axiRd(ocs_pkg::STAT_ADDR, 32'h05, ocs_pkg::RESP_OKAY);
      chk("rcEnable", 1'b0, rcEnable);
      chk("xtalEnable", 1'b0, xtalEnable);
      watch(16, 1'b1, 1'b1);
   endtask
   task automatic tTimebase();
      for (int s = 0; s < 4; s++) begin
         axiWr(ocs_pkg::TB_ADDR, 32'(s), ocs_pkg::RESP_OKAY);
         axiRd(ocs_pkg::TB_ADDR, 32'(s), ocs_pkg::RESP_OKAY);
         // RC and crystal are not the main source, so they stay dark
         watch(10, 1'b1, s == 0);
      end
      axiWr(ocs_pkg::TB_ADDR, 32'h00, ocs_pkg::RESP_OKAY);
   endtask
   task automatic tStaticSelect();
      axiWr(ocs_pkg::OPT_ADDR, 32'h03, ocs_pkg::RESP_OKAY);
      axiRd(ocs_pkg::OPT_ADDR, 32'h03, ocs_pkg::RESP_OKAY);
      axiRd(ocs_pkg::STAT_ADDR, 32'h05, ocs_pkg::RESP_OKAY);
      watch(12, 1'b1, 1'b1);
      chk("xtalEnable", 1'b0, xtalEnable);
   endtask
   task automatic tWaitBreak();
      @(posedge sys_clk);
      waitMode <= 1'b1;
      breakMode <= 1'b1;
      settle();
      watch(12, 1'b1, 1'b1);
      @(posedge sys_clk);
      waitMode <= 1'b0;
      watch(12, 1'b1, 1'b1);
      @(posedge sys_clk);
      breakMode <= 1'b0;
   endtask
   task automatic tStop();
      // Keep bits set first: only the ring circuit may run here
      axiWr(ocs_pkg::TB_ADDR, 32'h0c, ocs_pkg::RESP_OKAY);
      @(posedge sys_clk);
      stopMode <= 1'b1;
      settle();
      chk("ringEnable", 1'b1, ringEnable);
      chk("rcEnable", 1'b0, rcEnable);
      watch(10, 1'b1, 1'b1);
      @(posedge sys_clk);
      stopMode <= 1'b0;
      axiWr(ocs_pkg::TB_ADDR, 32'h10, ocs_pkg::RESP_OKAY);
      @(posedge sys_clk);
      stopMode <= 1'b1;
      settle();
      chk("ringEnable", 1'b0, ringEnable);
      axiRd(ocs_pkg::STAT_ADDR, 32'h21, ocs_pkg::RESP_OKAY);
      watch(10, 1'b0, 1'b0);
      @(posedge sys_clk);
      stopMode <= 1'b0;
      settle();
      chk("ringEnable", 1'b1, ringEnable);
      axiWr(ocs_pkg::TB_ADDR, 32'h00, ocs_pkg::RESP_OKAY);
   endtask
   task automatic tGlobalEnable();
      @(posedge sys_clk);
      oscGlobalEnable <= 1'b0;
      settle();
      chk("ringEnable", 1'b0, ringEnable);
      @(posedge sys_clk);
      oscGlobalEnable <= 1'b1;
      settle();
      chk("ringEnable", 1'b1, ringEnable);
      watch(8, 1'b1, 1'b1);
   endtask
   task automatic tBusErrors();
      axiWr(20'h00100, 32'h5a, ocs_pkg::RESP_SLVERR);
      axiRd(20'h00100, 32'h00, ocs_pkg::RESP_SLVERR);
      axiWr(ocs_pkg::STAT_ADDR, 32'hff, ocs_pkg::RESP_OKAY);
      axiRd(ocs_pkg::STAT_ADDR, 32'h05, ocs_pkg::RESP_OKAY);
      // Lane 0 strobe low: answered but lands nowhere
      wstrb <= 4'h0;
      axiWr(ocs_pkg::TB_ADDR, 32'h1f, ocs_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      axiRd(ocs_pkg::TB_ADDR, 32'h00, ocs_pkg::RESP_OKAY);
   endtask
   task automatic pulseReset();
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle();
      expTb = ocs_pkg::TB_INT;
   endtask
   // Option word 0x03 was written earlier; a reset applies it
   task automatic tSourceSelect();
      pulseReset();
      expSel = ocs_pkg::MAIN_XTAL;
      axiRd(ocs_pkg::STAT_ADDR, 32'h17, ocs_pkg::RESP_OKAY);
      chk("rcEnable", 1'b0, rcEnable);
      axiWr(ocs_pkg::TB_ADDR, 32'h02, ocs_pkg::RESP_OKAY);
      expTb = ocs_pkg::TB_XTAL;
      watch(12, 1'b1, 1'b1);
      @(posedge sys_clk);
      stopMode <= 1'b1;
      settle();
      chk("xtalEnable", 1'b0, xtalEnable);
      watch(8, 1'b0, 1'b0);
      @(posedge sys_clk);
      stopMode <= 1'b0;
      axiWr(ocs_pkg::TB_ADDR, 32'h0a, ocs_pkg::RESP_OKAY);
      @(posedge sys_clk);
      stopMode <= 1'b1;
      settle();
      chk("xtalEnable", 1'b1, xtalEnable);
      watch(8, 1'b1, 1'b1);
      @(posedge sys_clk);
      stopMode <= 1'b0;
      // The PLL reference follows whichever main source is chosen, ring included
      axiWr(ocs_pkg::OPT_ADDR, 32'h02, ocs_pkg::RESP_OKAY);
      pulseReset();
      expSel = ocs_pkg::MAIN_RC;
      axiRd(ocs_pkg::STAT_ADDR, 32'h0e, ocs_pkg::RESP_OKAY);
      watch(12, 1'b1, 1'b1);
      axiWr(ocs_pkg::TB_ADDR, 32'h02, ocs_pkg::RESP_OKAY);
      watch(8, 1'b1, 1'b0);
      axiWr(ocs_pkg::TB_ADDR, 32'h01, ocs_pkg::RESP_OKAY);
      expTb = ocs_pkg::TB_RC;
      watch(8, 1'b1, 1'b1);
      @(posedge sys_clk);
      stopMode <= 1'b1;
      settle();
      chk("rcEnable", 1'b0, rcEnable);
      watch(6, 1'b0, 1'b0);
      @(posedge sys_clk);
      stopMode <= 1'b0;
      axiWr(ocs_pkg::OPT_ADDR, 32'h01, ocs_pkg::RESP_OKAY);
      pulseReset();
      expSel = ocs_pkg::MAIN_INT;
      axiRd(ocs_pkg::STAT_ADDR, 32'h05, ocs_pkg::RESP_OKAY);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0; oscGlobalEnable = 1'b1; waitMode = 1'b0;
      stopMode = 1'b0; breakMode = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
      awaddr = 20'h0; wdata = 32'h0; wstrb = 4'hf; bready = 1'b0;
      arvalid = 1'b0; araddr = 20'h0; rready = 1'b0;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle();
      tResetValues();
      tTimebase();
      tStaticSelect();
      tWaitBreak();
      tStop();
      tGlobalEnable();
      tBusErrors();
      tSourceSelect();
      print_verdict();
   end
   // The whole sequence needs well under 2000 cycles
   initial begin
      #200000;
      nMismatch++;
      print_verdict();
   end
endmodule
